// ### src/sdf_cubic_sinc_decimator.sv
// Third-order sinc decimator with modulator clock generation and output buffer
//
// Contract
// - Three integrators followed by three differentiators give a sinc3 response.
// - Bitstream sampled at modulator clock rise; zero maps to 0, one to 1.
// - Accumulators update at modulator clock fall, each adding the previous stage.
// - Reset clears accumulators, differences, delays, word counter and strobe.
// - On strobe rise compute three cascaded differences starting from third accumulator.
// - One output word per decimation ratio modulator clocks.
// - Full result is three times log2 ratio wide; top 16 bits are output.
// - Ratios 32 to 4096 in powers of two, each with its own window.
// - Larger ratios saturate when 17-bit window is 0x10000, else lower 16 bits.
// - At 20 MHz the word rates and result widths match the listed pairs.
// - The -3 dB point lies at 0.262 times the output word rate.
module sdf_cubic_sinc_decimator #(
    parameter int ACC_W = sdf_pkg::ACC_W,
    parameter int HALF_CYC = sdf_pkg::MOD_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic modulatorBitstream,
    input wire logic [sdf_pkg::FACTOR_W-1:0] decimationFactor,
    input wire logic wordReady,
    output logic modulatorClockIn,
    output logic wordStrobe,
    output logic wordValid,
    output logic [sdf_pkg::OUT_W-1:0] wordData,
    output logic wordSaturated
);
    if (ACC_W != sdf_pkg::ACC_W) begin : gBadWidth
        $error("Datapath must be 37 bits wide");
    end
    if (HALF_CYC < 1 || HALF_CYC > 255) begin : gBadHalf
        $error("Half period must lie in 1 to 255");
    end

    logic [7:0] halfCnt_reg;
    logic modClk_reg;
    logic bitSync1_reg;
    logic bitSync2_reg;
    logic inputBit_reg;
    logic [ACC_W-1:0] acc1_reg;
    logic [ACC_W-1:0] acc2_reg;
    logic [ACC_W-1:0] third_accumulator_reg;
    logic [ACC_W-1:0] acc3Dly_reg;
    logic [ACC_W-1:0] diff1_reg;
    logic [ACC_W-1:0] diff2_reg;
    logic [ACC_W-1:0] third_difference_reg;
    logic [ACC_W-1:0] diff1Dly_reg;
    logic [ACC_W-1:0] diff2Dly_reg;
    logic [sdf_pkg::FACTOR_W-1:0] wordCount_reg;
    logic wordClk_reg;
    logic wordClkDly_reg;
    logic diffDone_reg;
    logic strobeArmed_reg;
    logic spareValid_reg;
    sdf_pkg::sdf_word_t out_reg;
    sdf_pkg::sdf_word_t spare_reg;
    sdf_pkg::sdf_word_t windowed;
    logic halfDone;
    logic riseTick;
    logic fallTick;
    logic wordRise;
    logic lastCount;
    logic midCount;
    logic pop;
    logic [5:0] lsb;
    logic [16:0] win;

    // Clock divider freezes while the buffer is full, so back-pressure stalls
    // the modulator itself instead of dropping a word
    assign halfDone = (halfCnt_reg == 8'(HALF_CYC - 1)) && !spareValid_reg;
    assign riseTick = halfDone && !modClk_reg;
    assign fallTick = halfDone && modClk_reg;
    assign lastCount = (wordCount_reg == decimationFactor - 16'h0001);
    assign midCount = (wordCount_reg == (decimationFactor >> 1) - 16'h0001);
    assign wordRise = wordClk_reg && !wordClkDly_reg;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            halfCnt_reg <= 8'h00;
            modClk_reg <= 1'b0;
        end else if (halfDone) begin
            halfCnt_reg <= 8'h00;
            modClk_reg <= !modClk_reg;
        end else if (!spareValid_reg) begin
            halfCnt_reg <= halfCnt_reg + 8'h01;
        end
    end
    assign modulatorClockIn = modClk_reg;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bitSync1_reg <= 1'b0;
            bitSync2_reg <= 1'b0;
        end else begin
            bitSync1_reg <= modulatorBitstream;
            bitSync2_reg <= bitSync1_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            inputBit_reg <= 1'b0;
        end else if (riseTick) begin
            inputBit_reg <= bitSync2_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc1_reg <= '0;
            acc2_reg <= '0;
            third_accumulator_reg <= '0;
        end else if (fallTick) begin
            acc1_reg <= acc1_reg + {{(ACC_W-1){1'b0}}, inputBit_reg};
            acc2_reg <= acc2_reg + acc1_reg;
            third_accumulator_reg <= third_accumulator_reg + acc2_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wordCount_reg <= 16'h0000;
            wordClk_reg <= 1'b0;
        end else if (riseTick) begin
            wordCount_reg <= lastCount ? 16'h0000 : wordCount_reg + 16'h0001;
            if (midCount) begin
                wordClk_reg <= 1'b1;
            end else if (lastCount) begin
                wordClk_reg <= 1'b0;
            end
        end
    end

    // Differences run once per word on the strobe's rising edge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wordClkDly_reg <= 1'b0;
            diffDone_reg <= 1'b0;
            acc3Dly_reg <= '0;
            diff1Dly_reg <= '0;
            diff2Dly_reg <= '0;
            diff1_reg <= '0;
            diff2_reg <= '0;
            third_difference_reg <= '0;
        end else begin
            wordClkDly_reg <= wordClk_reg;
            diffDone_reg <= wordRise;
            if (wordRise) begin
                diff1_reg <= third_accumulator_reg - acc3Dly_reg;
                diff2_reg <= diff1_reg - diff1Dly_reg;
                third_difference_reg <= diff2_reg - diff2Dly_reg;
                acc3Dly_reg <= third_accumulator_reg;
                diff1Dly_reg <= diff1_reg;
                diff2Dly_reg <= diff2_reg;
            end
        end
    end

    // Window lies at 3*log2(ratio)-16, keeping the 16 most significant bits
    always_comb begin
        case (decimationFactor)
            sdf_pkg::FACTOR_64: lsb = sdf_pkg::LSB_64;
            sdf_pkg::FACTOR_128: lsb = sdf_pkg::LSB_128;
            sdf_pkg::FACTOR_256: lsb = sdf_pkg::LSB_256;
            sdf_pkg::FACTOR_512: lsb = sdf_pkg::LSB_512;
            sdf_pkg::FACTOR_1024: lsb = sdf_pkg::LSB_1024;
            sdf_pkg::FACTOR_2048: lsb = sdf_pkg::LSB_2048;
            sdf_pkg::FACTOR_4096: lsb = sdf_pkg::LSB_4096;
            default: lsb = sdf_pkg::LSB_256;
        endcase
        win = third_difference_reg[lsb +: 17];
        if (decimationFactor == sdf_pkg::FACTOR_32) begin
            windowed.saturated = (third_difference_reg[15:0] == sdf_pkg::SAT_32);
            windowed.word = windowed.saturated ? sdf_pkg::WORD_FULL : {third_difference_reg[14:0], 1'b0};
        end else begin
            windowed.saturated = (win == sdf_pkg::SAT_WIN);
            windowed.word = windowed.saturated ? sdf_pkg::WORD_FULL : win[15:0];
        end
    end

    // Strobe spans one full modulator period, stretched while a full buffer freezes the clock
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wordStrobe <= 1'b0;
            strobeArmed_reg <= 1'b1;
        end else if (riseTick) begin
            if (midCount && strobeArmed_reg) begin
                wordStrobe <= 1'b1;
                strobeArmed_reg <= 1'b0;
            end else if (lastCount && !strobeArmed_reg) begin
                wordStrobe <= 1'b0;
                strobeArmed_reg <= 1'b1;
            end else begin
                wordStrobe <= 1'b0;
            end
        end
    end

    // Two-entry skid buffer: output register plus one spare
    assign pop = wordValid && wordReady;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wordValid <= 1'b0;
            out_reg <= '0;
            spareValid_reg <= 1'b0;
            spare_reg <= '0;
        end else if (pop || !wordValid) begin
            if (spareValid_reg) begin
                out_reg <= spare_reg;
                wordValid <= 1'b1;
                spareValid_reg <= diffDone_reg;
                if (diffDone_reg) begin
                    spare_reg <= windowed;
                end
            end else begin
                wordValid <= diffDone_reg;
                if (diffDone_reg) begin
                    out_reg <= windowed;
                end
            end
        end else if (diffDone_reg) begin
            spare_reg <= windowed;
            spareValid_reg <= 1'b1;
        end
    end
    assign wordData = out_reg.word;
    assign wordSaturated = out_reg.saturated;
endmodule

// ### src/sdf_pkg.sv
// Constants and carrier types for the cubic sinc decimator
package sdf_pkg;
    localparam int ACC_W = 37;
    localparam int OUT_W = 16;
    localparam int FACTOR_W = 16;
    localparam int REF_CLK_MHZ = 250;
    // Shortest modulator clock period allowed, in ns
    localparam int MOD_PERIOD_MIN_NS = 50;
    // Half period in reference cycles, rounded up so the limit is never exceeded
    localparam int MOD_HALF_CYC = (MOD_PERIOD_MIN_NS * REF_CLK_MHZ + 1999) / 2000;
    localparam logic [FACTOR_W-1:0] FACTOR_32 = 16'h0020;
    localparam logic [FACTOR_W-1:0] FACTOR_64 = 16'h0040;
    localparam logic [FACTOR_W-1:0] FACTOR_128 = 16'h0080;
    localparam logic [FACTOR_W-1:0] FACTOR_256 = 16'h0100;
    localparam logic [FACTOR_W-1:0] FACTOR_512 = 16'h0200;
    localparam logic [FACTOR_W-1:0] FACTOR_1024 = 16'h0400;
    localparam logic [FACTOR_W-1:0] FACTOR_2048 = 16'h0800;
    localparam logic [FACTOR_W-1:0] FACTOR_4096 = 16'h1000;
    localparam logic [5:0] LSB_64 = 6'h02;
    localparam logic [5:0] LSB_128 = 6'h05;
    localparam logic [5:0] LSB_256 = 6'h08;
    localparam logic [5:0] LSB_512 = 6'h0B;
    localparam logic [5:0] LSB_1024 = 6'h0E;
    localparam logic [5:0] LSB_2048 = 6'h11;
    localparam logic [5:0] LSB_4096 = 6'h14;
    localparam logic [15:0] SAT_32 = 16'h8000;
    localparam logic [16:0] SAT_WIN = 17'h10000;
    localparam logic [15:0] WORD_FULL = 16'hFFFF;

    typedef struct packed {
        logic saturated;
        logic [OUT_W-1:0] word;
    } sdf_word_t;
endpackage

// ### tb/sdf_checker.sv
// Port assertions for the cubic sinc decimator
module sdf_checker #(
    parameter int HALF_CYC = 4
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [sdf_pkg::FACTOR_W-1:0] decimationFactor,
    input wire logic wordReady,
    input wire logic modulatorClockIn,
    input wire logic wordStrobe,
    input wire logic wordValid,
    input wire logic [sdf_pkg::OUT_W-1:0] wordData,
    input wire logic wordSaturated
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] phase, stbLen, riseCnt;
    logic seen;
    // Phase is only timed after a first edge, so the start-up phase is never judged
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 16'h0000;
            stbLen <= 16'h0000;
            riseCnt <= 16'h0000;
            seen <= 1'b0;
        end else begin
            phase <= $changed(modulatorClockIn) ? 16'h0001 : phase + 16'(phase != 16'h0000);
            stbLen <= wordStrobe ? stbLen + 16'h0001 : 16'h0000;
            seen <= seen | $rose(wordStrobe);
            riseCnt <= $rose(wordStrobe) ? 16'h0000 : riseCnt + 16'($rose(modulatorClockIn));
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    sequence pushSeq;
        ##[1:4] wordValid;
    endsequence
    reset_clear_a: assert property (disable iff (1'b0)
        !arst_n |-> !(wordValid | wordStrobe | modulatorClockIn)) else $error("not cleared");
    strobe_width_a: assert property ($fell(wordStrobe) |-> stbLen >= 16'(2 * HALF_CYC))
        else $error("strobe too short");
    word_period_a: assert property (seen && $rose(wordStrobe) |->
        riseCnt == decimationFactor - 16'h0001) else $error("word period wrong");
    first_word_a: assert property (!seen && $rose(wordStrobe) |->
        riseCnt == (decimationFactor >> 1) - 16'h0001) else $error("first strobe late");
    phase_len_a: assert property ($changed(modulatorClockIn) && phase != 16'h0000 |->
        phase >= 16'(HALF_CYC)) else $error("modulator phase short");
    valid_hold_a: assert property (wordValid && !wordReady |=>
        wordValid && $stable(wordData) && $stable(wordSaturated)) else $error("word lost");
    word_follows_a: assert property ($rose(wordStrobe) && !wordValid |-> pushSeq)
        else $error("no word after strobe");
    sat_word_a: assert property (wordValid && wordSaturated |->
        wordData == sdf_pkg::WORD_FULL) else $error("saturated word not full");
endmodule
bind sdf_cubic_sinc_decimator sdf_checker #(.HALF_CYC(HALF_CYC)) chk (.ref_clk(ref_clk),
    .arst_n(arst_n), .decimationFactor(decimationFactor), .wordReady(wordReady),
    .modulatorClockIn(modulatorClockIn), .wordStrobe(wordStrobe), .wordValid(wordValid),
    .wordData(wordData), .wordSaturated(wordSaturated));

// ### tb/sdf_modulator_model.sv
// Behavioural modulator clocked by the filter's modulator clock
module sdf_modulator_model (
    input wire logic modClk,
    input wire logic [1:0] mode,
    output logic bitOut
);
    timeunit 1ns;
    timeprecision 100ps;
    initial bitOut = 1'b0;
    // Changing at the fall keeps the bit steady across the sampling rise
    always @(negedge modClk) begin
        bitOut <= mode[1] ? ~bitOut : mode[0];
    end
endmodule

// ### tb/sdf_cubic_sinc_decimator_bench.sv
// Self-checking bench for the cubic sinc decimator
module sdf_cubic_sinc_decimator_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HC = 4;
    logic ref_clk, arst_n, bitIn, wordReady, modClk, wordStrobe, wordValid, wordSat, gotSat;
    logic [15:0] factor, wordData, gotData;
    logic [1:0] mode;
    int mismatches, check_count;
    time lastT;
    sdf_cubic_sinc_decimator #(.HALF_CYC(HC)) DUT (.ref_clk(ref_clk), .arst_n(arst_n),
        .modulatorBitstream(bitIn), .decimationFactor(factor), .wordReady(wordReady),
        .modulatorClockIn(modClk), .wordStrobe(wordStrobe), .wordValid(wordValid),
        .wordData(wordData), .wordSaturated(wordSat));
    sdf_modulator_model MOD (.modClk(modClk), .mode(mode), .bitOut(bitIn));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic test_done();
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h wanted %h", $time, what, got, exp);
        end
    endtask
    task automatic restart(input logic [15:0] f, input logic [1:0] m);
        @(posedge ref_clk);
        arst_n <= 1'b0;
        factor <= f;
        mode <= m;
        repeat (6) @(posedge ref_clk);
        check({15'h0, wordValid | modClk | wordStrobe}, 16'h0000, "reset");
        arst_n <= 1'b1;
    endtask
    // A word is taken at the edge after it is seen, since wordReady is high
    task automatic get_word();
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (wordValid !== 1'b1 && n < 50000);
        if (n >= 50000) begin
            mismatches++;
            $display("mismatch at %0t: no word", $time);
            test_done();
        end else begin
            gotData = wordData;
            gotSat = wordSat;
            lastT = $time;
        end
    endtask
    task automatic window_table();
        logic [15:0] f[9] = '{16'h0020, 16'h0020, 16'h0020, 16'h0040, 16'h0040,
            16'h0080, 16'h0100, 16'h0200, 16'h0064};
        logic [1:0] m[9] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h1};
        logic [15:0] e[9] = '{16'hFFFF, 16'h8000, 16'h0000, 16'hFFFF, 16'h8000,
            16'h8000, 16'hFFFF, 16'h8000, 16'h0F42};
        for (int i = 0; i < 9; i++) begin
            restart(f[i], m[i]);
            // Sixth word is the first whose differences all see real accumulator samples
            repeat (6) get_word();
            check(gotData, e[i], "word");
            check({15'h0, gotSat}, {15'h0, e[i] == 16'hFFFF}, "saturated");
        end
    endtask
    task automatic stall_test();
        int edges;
        logic lvl;
        time t3;
        restart(16'h0020, 2'h1);
        repeat (4) get_word();
        @(posedge ref_clk);
        wordReady <= 1'b0;
        repeat (1200) @(posedge ref_clk);
        #1;
        lvl = modClk;
        edges = 0;
        repeat (100) begin
            @(posedge ref_clk);
            #1;
            edges += int'(modClk !== lvl);
        end
        check(16'(edges), 16'h0000, "clock runs while full");
        check({15'h0, wordValid}, 16'h0001, "word dropped");
        @(posedge ref_clk);
        wordReady <= 1'b1;
        repeat (2) begin
            get_word();
            check(gotData, 16'hFFFF, "held word");
        end
        get_word();
        t3 = lastT;
        get_word();
        check(16'(lastT - t3), 16'(64 * HC * 4), "word period");
    endtask
    initial begin
        arst_n = 1'b1;
        wordReady = 1'b1;
        factor = 16'h0020;
        mode = 2'h0;
        mismatches = 0;
        check_count = 0;
        // Reset falls after time zero so no flop can miss its edge
        #1;
        arst_n = 1'b0;
        window_table();
        stall_test();
        test_done();
    end
endmodule
